/* bench/ext_slave.sv */
// External slave model: delayed acknowledge or error, read data on enable
`timescale 1ns/1ps
module ext_slave (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] mode,
    input wire logic [1:0] delay,
    input wire logic [3:0] cs_n,
    input wire logic oe_n,
    input wire logic [22:0] addr,
    output logic xfer_ack_n,
    output logic xfer_error_ack_n,
    output logic [31:0] data_in
);
    logic [2:0] cnt;
    logic [31:0] last;
    always @(posedge clk) begin
        if (reset || cs_n == 4'hF) begin
            cnt <= 3'h0;
            xfer_ack_n <= 1'h1;
            xfer_error_ack_n <= 1'h1;
        end else begin
            if (cnt != 3'h7) cnt <= cnt + 3'h1;
            // Held until the select drops
            if (cnt >= {1'h0, delay}) begin
                xfer_ack_n <= ~mode[0];
                xfer_error_ack_n <= ~mode[1];
            end
        end
        if (reset) last <= 32'h0;
        else if (!oe_n) last <= data_in;
    end
    // Released lines show the inverse so stale data cannot pass
    assign data_in = oe_n ? ~last : {addr[15:0], ~addr[15:0]};
endmodule

/* bench/testbench.sv */
// Self-checking bench for the external bus master
`timescale 1ns/1ps
`include "ebi_regs.svh"
module testbench;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic req_valid = 1'h0, req_write = 1'h0, req_port16 = 1'h0;
    logic req_we_mode = 1'h0, req_abort = 1'h0, cs_ack = 1'h0;
    logic int_done = 1'h0, use_cs = 1'h0, emulation_mode = 1'h0;
    logic show_cycle_enable_bit = 1'h0, monitor_scope_bit = 1'h1;
    logic debug_mode = 1'h0, monitor_debug_off = 1'h0;
    logic [22:0] req_addr = 23'h0;
    logic [1:0] req_size = 2'h0, monitor_timeout_sel = 2'h0;
    logic [1:0] pmode = 2'h1, pdelay = 2'h0;
    logic [2:0] req_code = 3'h0;
    logic [3:0] req_cs_n = 4'hE;
    logic [31:0] req_wdata = 32'h0, int_data = 32'h0;
    ebi_pkg::target_t req_target = ebi_pkg::TGT_EXTERNAL;
    logic busy, resp_done, resp_error, rw, oe_n, data_oe_n, show_strobe;
    logic xfer_ack_n, xfer_error_ack_n;
    logic [31:0] resp_rdata, data_out, data_in;
    logic [22:0] addr, s_addr, l_addr;
    logic [1:0] xfer_size, emul_access_code, s_size, l_size, s_emul;
    logic [2:0] xfer_code, s_code;
    logic [3:0] cs_n, byte_lane_enable_n, s_lane, cq;
    logic seen, bseen, dseen, anyen, sq, s_rw, s_oe;
    logic [31:0] s_dout;
    logic [15:0] seed = 16'h84AA;
    int ncyc, ndone, falls, n, miscompares = 0, checks = 0, cyc = 0;
    ebi_pkg::target_t tg[3] = '{ebi_pkg::TGT_PORT, ebi_pkg::TGT_MODULE,
        ebi_pkg::TGT_INTERNAL};
    logic [1:0] ec[3] = '{`EMUL_PORT, `EMUL_MODULE, `EMUL_INTERNAL};

    ebi_master u_dut (.clk, .reset, .req_valid, .req_write, .req_addr,
        .req_size, .req_code, .req_target, .req_cs_n, .req_port16,
        .req_we_mode, .req_wdata, .req_abort, .cs_ack, .int_done, .int_data,
        .xfer_ack_n, .xfer_error_ack_n, .data_in, .emulation_mode,
        .show_cycle_enable_bit, .show_strobe_enable(1'h1),
        .monitor_timeout_sel, .monitor_scope_bit, .debug_mode,
        .monitor_debug_off, .busy, .resp_done, .resp_error, .resp_rdata,
        .addr, .rw, .xfer_size, .xfer_code, .cs_n, .oe_n,
        .byte_lane_enable_n, .data_out, .data_oe_n, .show_strobe,
        .emul_access_code);
    ext_slave u_slave (.clk, .reset, .mode(pmode), .delay(pdelay), .cs_n,
        .oe_n, .addr, .xfer_ack_n, .xfer_error_ack_n, .data_in);

    always #12.5 clk = ~clk;

    // Snapshot of each bus cycle, cleared when a request is taken
    always @(posedge clk) begin
        sq <= show_strobe;
        cq <= cs_n;
        cs_ack <= use_cs && cs_n != 4'hF;
        if (req_valid && !busy) begin
            {seen, bseen, dseen, anyen} <= 4'h0;
            {ncyc, ndone, falls} <= '0;
        end else begin
            // A split access keeps the select low; its strobe marks each half
            if (cs_n != 4'hF && (cq == 4'hF || (sq && !show_strobe))) begin
                ncyc <= ncyc + 1;
                {l_addr, l_size} <= {addr, xfer_size};
                if (!seen) {s_addr, s_size, s_code, s_rw, s_oe, s_lane} <=
                    {addr, xfer_size, xfer_code, rw, oe_n, byte_lane_enable_n};
                seen <= 1'h1;
            end
            if (busy && !bseen) {bseen, s_emul} <= {1'h1, emul_access_code};
            if (!data_oe_n && !dseen) {dseen, s_dout} <= {1'h1, data_out};
            if (!oe_n || byte_lane_enable_n != 4'hF) anyen <= 1'h1;
            if (sq && !show_strobe) falls <= falls + 1;
            if (resp_done) ndone <= ndone + 1;
        end
        cyc++;
        // Ceiling well above the roughly 600 cycles the tests need
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [3:0] lanes_exp(input logic [1:0] sz,
            input logic [1:0] a);
        if (sz == `SIZE_BYTE) return ~(4'h1 << a);
        if (sz == `SIZE_HALF) return a[1] ? 4'h3 : 4'hC;
        return 4'h0;
    endfunction

    task automatic check(input string nm, input logic [31:0] got,
            input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic req(input logic w, input logic [22:0] a,
            input logic [1:0] sz, input ebi_pkg::target_t t,
            input logic p16, input logic we);
        seed = lfsr(seed);
        @(posedge clk);
        req_valid <= 1'h1;
        {req_write, req_addr, req_size, req_target} <= {w, a, sz, t};
        {req_port16, req_we_mode, req_code} <= {p16, we, seed[2:0]};
        req_wdata <= {seed, ~seed};
        int_data <= {~seed, seed};
        @(posedge clk);
        req_valid <= 1'h0;
    endtask

    task automatic run(input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!resp_done && n < lim);
        check("done", resp_done, 1'h1);
    endtask

    task automatic fin(input string nm);
        repeat (3) @(posedge clk);
        #1;
        $display("test %s finished", nm);
    endtask

    initial begin
        logic w;
        logic [1:0] sz;
        logic [22:0] a;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        #1;
        check("rst_sel", {cs_n, oe_n, byte_lane_enable_n}, 9'h1FF);
        check("rst_bus", {data_oe_n, show_strobe, busy}, 3'h6);
        check("rst_emul", emul_access_code, `EMUL_RESET);
        fin("reset");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            w = seed[4];
            sz = seed[3:2] == 2'h0 ? `SIZE_BYTE :
                seed[3:2] == 2'h1 ? `SIZE_HALF : `SIZE_WORD;
            a = {7'h0, seed[15:2], sz == `SIZE_BYTE ? seed[1:0] :
                sz == `SIZE_HALF ? {seed[1], 1'h0} : 2'h0};
            use_cs <= seed[5];
            pmode <= seed[5] ? 2'h0 : 2'h1;
            pdelay <= seed[7:6];
            req(w, a, sz, ebi_pkg::TGT_EXTERNAL, 1'h0, 1'h0);
            run(40);
            check("err", resp_error, 1'h0);
            if (!w && sz == `SIZE_WORD)
                check("rdata", resp_rdata, {a[15:0], ~a[15:0]});
            if (w) check("lane_off", byte_lane_enable_n, 4'hF);
            fin("random");
            check("rw", s_rw, !w);
            check("oe", s_oe, w);
            check("addr", {s_addr, s_size, s_code}, {a, sz, seed[2:0]});
            check("lane", s_lane, lanes_exp(sz, a[1:0]));
            check("emul", s_emul, `EMUL_EXTERNAL);
            check("strobe", falls, 1);
            if (w && sz == `SIZE_WORD)
                check("wdata", s_dout, {seed, ~seed});
        end
        {use_cs, pmode} <= 3'h1;
        req(1'h0, 23'h000400, `SIZE_WORD, ebi_pkg::TGT_EXTERNAL, 1'h0, 1'h1);
        run(40);
        fin("we_mode");
        check("we_lane", {s_oe, s_lane}, 5'h0F);
        req(1'h0, 23'h000800, `SIZE_WORD, ebi_pkg::TGT_EXTERNAL, 1'h1, 1'h0);
        run(60);
        check("rd16", resp_rdata, 32'h0800_0802);
        fin("port16");
        check("cyc16", ncyc, 2);
        check("done16", ndone, 1);
        check("first16", {s_addr, s_size}, {23'h000800, `SIZE_WORD});
        check("second16", {l_addr, l_size}, {23'h000802, `SIZE_HALF});
        for (int m = 2; m < 4; m++) begin
            pmode <= m[1:0];
            req(1'h0, 23'h000C00, `SIZE_WORD, ebi_pkg::TGT_EXTERNAL, 1'h0,
                1'h0);
            run(40);
            check("error", resp_error, 1'h1);
            fin("error");
        end
        pmode <= 2'h0;
        for (int s = 0; s < 4; s++) begin
            monitor_timeout_sel <= s[1:0];
            req(1'h1, 23'h001000, `SIZE_WORD, ebi_pkg::TGT_EXTERNAL, 1'h0,
                1'h0);
            run(100);
            check("tmo_err", resp_error, 1'h1);
            check("tmo_len", n >= (8 << s) && n <= (8 << s) + 6, 1);
            fin("timeout");
        end
        for (int k = 0; k < 2; k++) begin
            {monitor_scope_bit, debug_mode, monitor_debug_off} <= {3{k[0]}};
            req(1'h0, 23'h001400, `SIZE_WORD, ebi_pkg::TGT_EXTERNAL, 1'h0,
                1'h0);
            repeat (80) @(posedge clk);
            #1;
            check("hang", {busy, ndone[3:0]}, 5'h10);
            @(posedge clk);
            req_abort <= 1'h1;
            n = 0;
            while (busy !== 1'h0 && n < 10) begin
                @(posedge clk);
                #1;
                n++;
            end
            @(posedge clk);
            req_abort <= 1'h0;
            fin("abort");
            check("abort", {busy, ndone[3:0]}, 5'h00);
            check("abort_pins", {seen, s_oe}, 2'h2);
        end
        {monitor_scope_bit, debug_mode, monitor_debug_off} <= 3'h4;
        pmode <= 2'h1;
        for (int k = 0; k < 6; k++) begin
            show_cycle_enable_bit <= k == 3 || k == 4;
            emulation_mode <= k == 5;
            req(1'h0, 23'h001800, `SIZE_WORD, tg[k % 3], 1'h0, 1'h0);
            repeat (2) @(posedge clk);
            int_done <= 1'h1;
            @(posedge clk);
            int_done <= 1'h0;
            #1;
            check("int_done", {resp_done, resp_error}, 2'h2);
            fin("internal");
            check("int_emul", s_emul, ec[k % 3]);
            check("show_en", anyen, 1'h0);
            check("show_data", dseen, k >= 3);
            if (k >= 3) check("show_val", s_dout, {~seed, seed});
            if (k >= 3) check("show_strobe", falls, 1);
        end
        give_verdict();
    end
endmodule

/* rtl/bus_monitor.sv */
// Bus response timer with selectable limit
`timescale 1ns/1ps
`include "ebi_regs.svh"
module bus_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic active,
    input wire logic [1:0] sel,
    output logic timeout
);
    ebi_pkg::mon_state_t s;
    ebi_pkg::mon_state_t next_s;
    logic [`MON_COUNT_W-1:0] limit;

    always_comb begin
        limit = `MON_BASE << sel;
        next_s = s;
        next_s.timeout = 1'b0;
        if (start) begin
            next_s.count = '0;
            next_s.run = active;
        end else if (s.run && active) begin
            if (s.count == limit - 7'h01) begin
                next_s.timeout = 1'b1;
                next_s.run = 1'b0;
            end
            next_s.count = s.count + 7'h01;
        end else begin
            next_s.run = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign timeout = s.timeout;
endmodule

/* rtl/ebi_master.sv */
// External bus master: cycle sequencer, show cycles, monitor hookup
`timescale 1ns/1ps
`include "ebi_regs.svh"
module ebi_master (
    input wire logic clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [22:0] req_addr,
    input wire logic [1:0] req_size,
    input wire logic [2:0] req_code,
    input wire ebi_pkg::target_t req_target,
    input wire logic [3:0] req_cs_n,
    input wire logic req_port16,
    input wire logic req_we_mode,
    input wire logic [31:0] req_wdata,
    input wire logic req_abort,
    input wire logic cs_ack,
    input wire logic int_done,
    input wire logic [31:0] int_data,
    input wire logic xfer_ack_n,
    input wire logic xfer_error_ack_n,
    input wire logic [31:0] data_in,
    input wire logic emulation_mode,
    input wire logic show_cycle_enable_bit,
    input wire logic show_strobe_enable,
    input wire logic [1:0] monitor_timeout_sel,
    input wire logic monitor_scope_bit,
    input wire logic debug_mode,
    input wire logic monitor_debug_off,
    output logic busy,
    output logic resp_done,
    output logic resp_error,
    output logic [31:0] resp_rdata,
    output logic [22:0] addr,
    output logic rw,
    output logic [1:0] xfer_size,
    output logic [2:0] xfer_code,
    output logic [3:0] cs_n,
    output logic oe_n,
    output logic [3:0] byte_lane_enable_n,
    output logic [31:0] data_out,
    output logic data_oe_n,
    output logic show_strobe,
    output logic [1:0] emul_access_code
);
    ebi_pkg::ebi_state_t s;
    ebi_pkg::ebi_state_t next_s;
    logic ack_n_s;
    logic err_n_s;
    logic [31:0] din_s;
    logic mon_timeout;
    logic mon_active;
    logic strobe_on;
    logic term_ack;
    logic term_err;

    pin_sync #(.W(2), .INIT(2'h3)) u_ctl_sync (
        .clk(clk),
        .reset(reset),
        .din({xfer_ack_n, xfer_error_ack_n}),
        .dout({ack_n_s, err_n_s})
    );

    pin_sync #(.W(32), .INIT(32'h0)) u_data_sync (
        .clk(clk),
        .reset(reset),
        .din(data_in),
        .dout(din_s)
    );

    // Scope bit and debug switch gate the timer per access
    assign mon_active = !(debug_mode && monitor_debug_off)
        && (s.is_int || monitor_scope_bit)
        && (s.st == ebi_pkg::ST_ADDR || s.st == ebi_pkg::ST_WAIT
            || s.st == ebi_pkg::ST_INT);

    bus_monitor u_monitor (
        .clk(clk),
        .reset(reset),
        .start(s.mon_start),
        .active(mon_active),
        .sel(monitor_timeout_sel),
        .timeout(mon_timeout)
    );

    function automatic logic [3:0] lane_mask(input logic [1:0] sz,
        input logic [1:0] a, input logic p16);
        logic [3:0] m;
        m = 4'hF;
        if (sz == `SIZE_BYTE) begin
            m = p16 ? (4'h1 << a[0]) : (4'h1 << a);
        end else if (sz == `SIZE_HALF || p16) begin
            m = (a[1] && !p16) ? 4'hC : 4'h3;
        end
        return m;
    endfunction

    // Narrow port carries the addressed half-word on the upper lanes
    function automatic logic [31:0] place(input logic [31:0] d,
        input logic a1, input logic p16);
        return (p16 && a1) ? {d[15:0], d[15:0]} : d;
    endfunction

    function automatic logic [1:0] emul_of(input ebi_pkg::target_t t);
        case (t)
            ebi_pkg::TGT_PORT: emul_of = `EMUL_PORT;
            ebi_pkg::TGT_MODULE: emul_of = `EMUL_MODULE;
            ebi_pkg::TGT_INTERNAL: emul_of = `EMUL_INTERNAL;
            default: emul_of = `EMUL_EXTERNAL;
        endcase
    endfunction

    assign strobe_on = show_strobe_enable || emulation_mode;
    assign term_err = !err_n_s || mon_timeout;
    assign term_ack = (!ack_n_s || cs_ack) && !(s.second && s.mon_start);

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.err = 1'b0;
        next_s.mon_start = 1'b0;
        next_s.show_en = emulation_mode || show_cycle_enable_bit;
        case (s.st)
            ebi_pkg::ST_IDLE: begin
                next_s.strobe = 1'b1;
                next_s.dout_oe_n = 1'b1;
                if (req_valid) begin
                    next_s.busy = 1'b1;
                    next_s.write = req_write;
                    next_s.port16 = req_port16;
                    next_s.second = 1'b0;
                    next_s.aborted = 1'b0;
                    next_s.error = 1'b0;
                    next_s.rdata = '0;
                    next_s.wdata = req_wdata;
                    next_s.addr = req_addr;
                    next_s.size = req_size;
                    next_s.code = req_code;
                    next_s.rw = !req_write;
                    next_s.emul = emul_of(req_target);
                    next_s.mon_start = 1'b1;
                    if (req_target == ebi_pkg::TGT_EXTERNAL) begin
                        next_s.is_int = 1'b0;
                        next_s.st = ebi_pkg::ST_ADDR;
                        if (req_size == `SIZE_WORD) begin
                            next_s.addr[1:0] = 2'h0;
                        end
                        next_s.cs_n = req_cs_n;
                        next_s.oe_n = req_write;
                        next_s.lane_n = (req_write || !req_we_mode)
                            ? ~lane_mask(req_size, req_addr[1:0],
                                req_port16) : 4'hF;
                        next_s.strobe = !strobe_on;
                    end else begin
                        next_s.is_int = 1'b1;
                        next_s.st = ebi_pkg::ST_INT;
                        next_s.strobe = !(strobe_on && next_s.show_en);
                    end
                end
            end
            ebi_pkg::ST_ADDR, ebi_pkg::ST_WAIT: begin
                if (s.write) begin
                    next_s.dout = place(s.wdata, s.addr[1], s.port16);
                    next_s.dout_oe_n = 1'b0;
                end
                if (req_abort) begin
                    next_s.aborted = 1'b1;
                    next_s.st = ebi_pkg::ST_DONE;
                    next_s.strobe = 1'b1;
                end else if (term_err) begin
                    next_s.error = 1'b1;
                    next_s.st = ebi_pkg::ST_DONE;
                    next_s.strobe = 1'b1;
                end else if (term_ack) begin
                    next_s.st = ebi_pkg::ST_DONE;
                    next_s.strobe = 1'b1;
                end else begin
                    next_s.st = ebi_pkg::ST_WAIT;
                end
            end
            ebi_pkg::ST_DONE: begin
                if (!s.write) begin
                    if (s.port16 && s.addr[1]) begin
                        next_s.rdata[15:0] = din_s[31:16];
                    end else if (s.port16) begin
                        next_s.rdata[31:16] = din_s[31:16];
                    end else begin
                        next_s.rdata = din_s;
                    end
                end
                next_s.lane_n = 4'hF;
                if (s.port16 && s.size == `SIZE_WORD && !s.second
                    && !s.error && !s.aborted) begin
                    next_s.second = 1'b1;
                    next_s.addr[1] = 1'b1;
                    next_s.size = `SIZE_HALF;
                    next_s.st = ebi_pkg::ST_ADDR;
                    next_s.mon_start = 1'b1;
                    next_s.lane_n = s.lane_n;
                    next_s.dout_oe_n = 1'b1;
                    next_s.strobe = !strobe_on;
                end else begin
                    next_s.st = ebi_pkg::ST_IDLE;
                    next_s.done = !s.aborted;
                    next_s.err = s.error && !s.aborted;
                    next_s.busy = 1'b0;
                    next_s.cs_n = 4'hF;
                    next_s.oe_n = 1'b1;
                    next_s.dout_oe_n = 1'b1;
                end
            end
            ebi_pkg::ST_INT: begin
                if (req_abort) begin
                    next_s.st = ebi_pkg::ST_IDLE;
                    next_s.busy = 1'b0;
                    next_s.strobe = 1'b1;
                end else if (mon_timeout || int_done) begin
                    next_s.done = 1'b1;
                    next_s.err = mon_timeout;
                    if (next_s.show_en && s.show_en) begin
                        next_s.st = ebi_pkg::ST_SHOW;
                        next_s.dout = int_data;
                        next_s.dout_oe_n = 1'b0;
                        next_s.strobe = 1'b1;
                    end else begin
                        next_s.st = ebi_pkg::ST_IDLE;
                        next_s.busy = 1'b0;
                        next_s.strobe = 1'b1;
                    end
                end
            end
            ebi_pkg::ST_SHOW: begin
                // Shown data stands one clock only
                next_s.st = ebi_pkg::ST_IDLE;
                next_s.busy = 1'b0;
                next_s.dout_oe_n = 1'b1;
            end
            default: begin
                next_s.st = ebi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.st <= ebi_pkg::ST_IDLE;
            s.cs_n <= 4'hF;
            s.oe_n <= 1'b1;
            s.rw <= 1'b1;
            s.lane_n <= 4'hF;
            s.dout_oe_n <= 1'b1;
            s.strobe <= 1'b1;
            s.emul <= `EMUL_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
    assign resp_done = s.done;
    assign resp_error = s.err;
    assign resp_rdata = s.rdata;
    assign addr = s.addr;
    assign rw = s.rw;
    assign xfer_size = s.size;
    assign xfer_code = s.code;
    assign cs_n = s.cs_n;
    assign oe_n = s.oe_n;
    assign byte_lane_enable_n = s.lane_n;
    assign data_out = s.dout;
    assign data_oe_n = s.dout_oe_n;
    assign show_strobe = s.strobe;
    assign emul_access_code = s.emul;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_EMUL_RESET: assert property (disable iff (1'b0)
        reset |=> emul_access_code == `EMUL_RESET)
        else $error("emulation code not 11 after reset");
    AST_READ_ENABLE: assert property (
        s.st == ebi_pkg::ST_ADDR && s.rw |-> !oe_n)
        else $error("read address phase without output enable");
    AST_READ_HOLD: assert property (
        s.st == ebi_pkg::ST_DONE && s.rw |-> $stable(addr)
        && $stable(cs_n) && $stable(oe_n) && $stable(xfer_size)
        && $stable(byte_lane_enable_n) && $stable(xfer_code))
        else $error("read outputs moved in completion");
    AST_WRITE_NO_OE: assert property (
        s.st == ebi_pkg::ST_ADDR && !s.rw |-> oe_n)
        else $error("output enable asserted on write");
    AST_WRITE_DATA: assert property (
        s.st == ebi_pkg::ST_ADDR && s.write && !req_abort
        |=> !data_oe_n)
        else $error("write data not driven after address phase");
    AST_LANES_OFF: assert property (
        s.st == ebi_pkg::ST_DONE
        |=> byte_lane_enable_n == 4'hF || s.st == ebi_pkg::ST_ADDR)
        else $error("lane enables not negated after completion");
    AST_ERROR_WINS: assert property (
        (s.st == ebi_pkg::ST_ADDR || s.st == ebi_pkg::ST_WAIT)
        && !err_n_s && !req_abort
        |=> s.st == ebi_pkg::ST_DONE && s.error ##1 resp_error)
        else $error("error acknowledge did not end cycle with error");
    AST_TIMEOUT_8: assert property (
        s.mon_start && mon_active && monitor_timeout_sel == 2'h0
        ##1 mon_active [*8] |=> mon_timeout)
        else $error("monitor missed 8 clock limit");
    AST_SHOW_QUIET: assert property (
        s.st == ebi_pkg::ST_SHOW
        |-> oe_n && byte_lane_enable_n == 4'hF && !data_oe_n)
        else $error("show cycle enables or data wrong");
    AST_INT_RELEASED: assert property (
        s.st == ebi_pkg::ST_INT |-> data_oe_n && cs_n == 4'hF)
        else $error("data bus driven during internal cycle");
    AST_STROBE_DATA: assert property (
        s.st == ebi_pkg::ST_ADDR && strobe_on && !req_abort
        && term_ack && !term_err |-> !show_strobe ##1 show_strobe)
        else $error("show strobe sequence wrong");

    COV_READ_WAIT: cover property (
        s.st == ebi_pkg::ST_WAIT && s.rw ##1 s.st == ebi_pkg::ST_DONE);
    COV_WRITE_FAST: cover property (
        s.st == ebi_pkg::ST_ADDR && !s.rw ##1 s.st == ebi_pkg::ST_DONE);
    COV_SHOW: cover property (s.st == ebi_pkg::ST_SHOW);
    COV_SPLIT: cover property (s.second && s.st == ebi_pkg::ST_DONE);
endmodule

/* rtl/ebi_pkg.sv */
// Types shared by the external bus master interface
package ebi_pkg;
    typedef enum {
        ST_IDLE, ST_ADDR, ST_WAIT, ST_DONE, ST_INT, ST_SHOW
    } bus_state_t;
    typedef enum logic [1:0] {
        TGT_EXTERNAL, TGT_PORT, TGT_MODULE, TGT_INTERNAL
    } target_t;
    typedef struct packed {
        bus_state_t st;
        logic write;
        logic port16;
        logic second;
        logic is_int;
        logic aborted;
        logic error;
        logic busy;
        logic show_en;
        logic mon_start;
        logic [22:0] addr;
        logic [1:0] size;
        logic [2:0] code;
        logic [3:0] cs_n;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic oe_n;
        logic rw;
        logic [3:0] lane_n;
        logic [31:0] dout;
        logic dout_oe_n;
        logic strobe;
        logic [1:0] emul;
        logic done;
        logic err;
    } ebi_state_t;
    typedef struct packed {
        logic [6:0] count;
        logic run;
        logic timeout;
    } mon_state_t;
endpackage

/* rtl/ebi_regs.svh */
// Constants for the external bus master interface
// Overview of operation
// - Read address phase drives address, read level, size, code, optional select.
// - Read address phase asserts output enable; lanes too unless write-enable mode.
// - Acknowledge or chip-select acknowledge moves address phase to completion.
// - Without acknowledge, whole-clock wait states are inserted.
// - Read completion passes the active data half-words inward.
// - Read strobes, address and status hold through completion.
// - Write address phase keeps output enable negated; write level and lanes.
// - Write data driven from first wait state, else in completion.
// - Write lanes negate after completion; address, data, status hold through.
// - Error acknowledge ends cycle with error, overriding normal acknowledge.
// - Monitor limit 8, 16, 32 or 64 clocks raises internal error.
// - Monitor count restarts at the start of every bus access.
// - Scope bit picks internal-only or all; debug may switch monitor off.
// - Word to 16-bit port is timed as two separate cycles.
// - Aborted cycles still drive address, status, select, enable, strobe.
// - Emulation code: 10 ports, 11 modules, 01 internal, 00 external.
// - Emulation code shows 11 during reset.
// - Show cycles keep enables negated; data shown the clock after.
// - Internal cycles drive status; data bus released without show cycles.
// - Show cycles forced in emulation mode, else by enable bit.
// - Show strobe low once for status, high once for data, per cycle.
// - Lane enables 0 to 3 map to D[31:24] down to D[7:0].
// - Word to 16-bit port: word size at offset 0, then half at 2.
`ifndef EBI_REGS_SVH
`define EBI_REGS_SVH
`define SIZE_BYTE 2'h1
`define SIZE_HALF 2'h2
`define SIZE_WORD 2'h0
`define EMUL_PORT 2'h2
`define EMUL_MODULE 2'h3
`define EMUL_INTERNAL 2'h1
`define EMUL_EXTERNAL 2'h0
`define EMUL_RESET 2'h3
`define MON_BASE 7'h08
`define MON_COUNT_W 7
`endif

/* rtl/pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s.s1 = din;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= {INIT, INIT};
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.s2;
endmodule
